// [dgs_pkg.sv]
// package of constants and types for the data group step sequencer
package dgs_pkg;
    // ************************************************************
    // condition types
    // ************************************************************
    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_DELAY = 2'h1;
    localparam logic [1:0] COND_EDGE = 2'h2;
    localparam logic [1:0] COND_LEVEL = 2'h3;
    // ************************************************************
    // relation between the two conditions
    // ************************************************************
    localparam logic [1:0] REL_NONE = 2'h0;
    localparam logic [1:0] REL_AND = 2'h1;
    localparam logic [1:0] REL_OR = 2'h2;
    // ************************************************************
    // edge selection and level selection values
    // ************************************************************
    localparam logic [15:0] EDGE_RISE = 16'h0000;
    localparam logic [15:0] EDGE_FALL = 16'h0001;
    localparam logic [15:0] EDGE_BOTH = 16'h0002;
    localparam logic [15:0] LEVEL_LOW = 16'h0004;
    // ************************************************************
    // speed limits and resets
    // ************************************************************
    localparam logic [12:0] SPEED_MAX = 13'h1770;
    localparam logic [12:0] SPEED_RESET = 13'h0064;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [1:0] TYPE_RESET = 2'h0;
    localparam logic [1:0] REL_RESET = 2'h0;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 125;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = CLK_MHZ * MS_US;
    localparam logic [16:0] MS_CYCLES_W = 17'(MS_CYCLES);
    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} dgs_state_t;
endpackage : dgs_pkg

// [dgs_cond_eval.sv]
// evaluation of one step-change condition
`timescale 1ns/10ps
module dgs_cond_eval #(
    parameter int MS_CYCLES = 125000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // control
    input wire logic start,
    input wire logic [1:0] condType,
    input wire logic [15:0] condValue,
    // sampled step-advance input and edges
    input wire logic advLevel,
    input wire logic advRise,
    input wire logic advFall,
    // result
    output logic met
);
    logic [16:0] tickCnt_q, tickCnt_d;
    logic [15:0] msCnt_q, msCnt_d;
    logic edgeSeen_q, edgeSeen_d;
    logic met_q, met_d;
    logic edgeHit;
    logic levelHit;

    always_comb begin
        case (condValue)
            dgs_pkg::EDGE_RISE: edgeHit = advRise; // RQ5
            dgs_pkg::EDGE_FALL: edgeHit = advFall; // RQ6
            dgs_pkg::EDGE_BOTH: edgeHit = advRise | advFall; // RQ6
            default: edgeHit = 1'b0;
        endcase
        // a level value of 4 asks for a low level, anything else high
        levelHit = (condValue == dgs_pkg::LEVEL_LOW) ? ~advLevel : advLevel;
    end

    always_comb begin
        tickCnt_d = tickCnt_q;
        msCnt_d = msCnt_q;
        edgeSeen_d = edgeSeen_q;
        met_d = met_q;
        if (start) begin
            tickCnt_d = 17'h00000;
            msCnt_d = 16'h0000;
            // an edge in the arming cycle already belongs to the new group
            edgeSeen_d = edgeHit;
            met_d = 1'b0;
        end else begin
            case (condType) // RQ1 RQ2
                dgs_pkg::COND_NONE: met_d = 1'b1; // RQ7
                dgs_pkg::COND_DELAY: begin
                    // RQ4: whole milliseconds counted from the start
                    if (msCnt_q == condValue) begin
                        met_d = 1'b1;
                    end else if (tickCnt_q == 17'(MS_CYCLES - 1)) begin
                        tickCnt_d = 17'h00000;
                        msCnt_d = msCnt_q + 16'h0001;
                    end else begin
                        tickCnt_d = tickCnt_q + 17'h00001;
                    end
                end
                dgs_pkg::COND_EDGE: begin
                    // an edge is latched so that the other condition may arrive later
                    if (edgeHit) begin
                        edgeSeen_d = 1'b1;
                    end
                    met_d = edgeSeen_q | edgeHit;
                end
                dgs_pkg::COND_LEVEL: met_d = levelHit;
                default: met_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tickCnt_q <= 17'h00000;
            msCnt_q <= 16'h0000;
            edgeSeen_q <= 1'b0;
            met_q <= 1'b0;
        end else begin
            tickCnt_q <= tickCnt_d;
            msCnt_q <= msCnt_d;
            edgeSeen_q <= edgeSeen_d;
            met_q <= met_d;
        end
    end

    assign met = met_q;
endmodule : dgs_cond_eval

// [dgs_step_sequencer.sv]
// data group step sequencer top: settings capture, condition join, step pulse
// Summary of operation
// RQ1 - first condition type decodes none, delay, input edge, input level
// RQ2 - second independent condition type with the same four choices
// RQ3 - conditions joined by none, AND or OR to decide the step
// RQ4 - delay condition waits value milliseconds, 0 to 65535
// RQ5 - edge condition with value 0 accepts a rising step-advance edge
// RQ6 - edge value 1 selects falling, value 2 either edge
// RQ7 - unconditional condition ignores its value and is met at once
// RQ8 - per-group speed 0 to 6000 rpm, default 100, applies after restart
// RQ9 - two condition values per group, 0 to 65535, reset 0, applied on restart
// RQ10 - outside party holds step-advance input stable long enough to sample
`timescale 1ns/10ps
module dgs_step_sequencer (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // group settings from parameters
    input wire logic [12:0] cfgSpeed,
    input wire logic [1:0] cfgType1,
    input wire logic [1:0] cfgType2,
    input wire logic [1:0] cfgRelation,
    input wire logic [15:0] cfgValue1,
    input wire logic [15:0] cfgValue2,
    // restart loads settings, start arms a group
    input wire logic restart,
    input wire logic startGroup,
    // step-advance input from the outside switch
    input wire logic stepAdvanceIn,
    // results
    output logic [12:0] groupSpeed,
    output logic busy,
    output logic stepChange
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rstSync1_q, rstN_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_q <= 1'b0;
            rstN_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstN_q <= rstSync1_q;
        end
    end

    // ************************************************************
    // settings, taken only at restart
    // ************************************************************
    logic [12:0] speed_q, speed_d;
    logic [1:0] type1_q, type1_d;
    logic [1:0] type2_q, type2_d;
    logic [1:0] rel_q, rel_d;
    logic [15:0] val1_q, val1_d;
    logic [15:0] val2_q, val2_d;

    // out of range speed is clamped rather than wrapping
    function automatic logic [12:0] clampSpeed(input logic [12:0] raw);
        if (raw > dgs_pkg::SPEED_MAX) begin
            clampSpeed = dgs_pkg::SPEED_MAX;
        end else begin
            clampSpeed = raw;
        end
    endfunction : clampSpeed

    always_comb begin
        speed_d = speed_q;
        type1_d = type1_q;
        type2_d = type2_q;
        rel_d = rel_q;
        val1_d = val1_q;
        val2_d = val2_q;
        if (restart) begin
            speed_d = clampSpeed(cfgSpeed); // RQ8
            type1_d = cfgType1; // RQ1
            type2_d = cfgType2; // RQ2
            rel_d = cfgRelation; // RQ3
            val1_d = cfgValue1; // RQ9
            val2_d = cfgValue2; // RQ9
        end
    end

    always_ff @(posedge core_clk or negedge rstN_q) begin
        if (!rstN_q) begin
            speed_q <= dgs_pkg::SPEED_RESET;
            type1_q <= dgs_pkg::TYPE_RESET;
            type2_q <= dgs_pkg::TYPE_RESET;
            rel_q <= dgs_pkg::REL_RESET;
            val1_q <= dgs_pkg::VALUE_RESET;
            val2_q <= dgs_pkg::VALUE_RESET;
        end else begin
            speed_q <= speed_d;
            type1_q <= type1_d;
            type2_q <= type2_d;
            rel_q <= rel_d;
            val1_q <= val1_d;
            val2_q <= val2_d;
        end
    end

    // ************************************************************
    // step-advance sampling and edges
    // ************************************************************
    // the input is taken as synchronous; it must stay one cycle to be seen
    // both flops reset to the idle low level, so no false edge follows reset
    logic adv_q, adv_d, advPrev_q, advPrev_d;
    logic advRise, advFall;

    always_comb begin
        adv_d = stepAdvanceIn;
        advPrev_d = adv_q;
    end

    always_ff @(posedge core_clk or negedge rstN_q) begin
        if (!rstN_q) begin
            adv_q <= 1'b0;
            advPrev_q <= 1'b0;
        end else begin
            adv_q <= adv_d;
            advPrev_q <= advPrev_d;
        end
    end
    assign advRise = adv_q & ~advPrev_q;
    assign advFall = ~adv_q & advPrev_q;

    // ************************************************************
    // condition evaluators
    // ************************************************************
    logic armPulse;
    logic met1, met2;

    // both evaluators share one sampled input, so one edge can satisfy both
    // conditions in the same cycle when they ask for it

    dgs_cond_eval #(
        .MS_CYCLES(dgs_pkg::MS_CYCLES)
    ) uCond1 (
        .clk(core_clk),
        .rstN(rstN_q),
        .start(armPulse),
        .condType(type1_q),
        .condValue(val1_q),
        .advLevel(adv_q),
        .advRise(advRise),
        .advFall(advFall),
        .met(met1)
    );

    dgs_cond_eval #(
        .MS_CYCLES(dgs_pkg::MS_CYCLES)
    ) uCond2 (
        .clk(core_clk),
        .rstN(rstN_q),
        .start(armPulse),
        .condType(type2_q),
        .condValue(val2_q),
        .advLevel(adv_q),
        .advRise(advRise),
        .advFall(advFall),
        .met(met2)
    );

    // ************************************************************
    // join and step sequencing
    // ************************************************************
    function automatic logic joinConds(input logic [1:0] rel, input logic a, input logic b);
        case (rel)
            dgs_pkg::REL_AND: joinConds = a & b;
            dgs_pkg::REL_OR: joinConds = a | b;
            // no connection: only the first condition decides
            default: joinConds = a;
        endcase
    endfunction : joinConds

    dgs_pkg::dgs_state_t state_q, state_d;
    logic step_q, step_d;
    logic joined;

    assign joined = joinConds(rel_q, met1, met2); // RQ3

    always_comb begin
        state_d = state_q;
        step_d = 1'b0;
        armPulse = 1'b0;
        case (state_q)
            dgs_pkg::ST_IDLE: begin
                if (startGroup) begin
                    armPulse = 1'b1;
                    state_d = dgs_pkg::ST_DONE;
                end
            end
            // one settle cycle so the evaluators see their cleared state;
            // restart aborts here too, so new settings meet a half-armed group only when restart and startGroup coincide in ST_IDLE
            dgs_pkg::ST_DONE: begin
                if (restart) begin
                    state_d = dgs_pkg::ST_IDLE;
                end else begin
                    state_d = dgs_pkg::ST_RUN;
                end
            end
            dgs_pkg::ST_RUN: begin
                if (restart) begin
                    state_d = dgs_pkg::ST_IDLE;
                end else if (joined) begin
                    step_d = 1'b1; // RQ3
                    state_d = dgs_pkg::ST_IDLE;
                end
            end
            default: state_d = dgs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN_q) begin
        if (!rstN_q) begin
            state_q <= dgs_pkg::ST_IDLE;
            step_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
        end
    end

    // busy is decoded from the state register; speed and step come from flops
    assign groupSpeed = speed_q;
    assign busy = (state_q != dgs_pkg::ST_IDLE);
    assign stepChange = step_q;
endmodule : dgs_step_sequencer

// [dgs_step_sequencer_monitor.sv]
// checker of the step sequencer port behaviour
`timescale 1ns/10ps
module dgs_step_sequencer_monitor (
    // clock, reset and settings
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [12:0] cfgSpeed,
    input wire logic [1:0] cfgType1,
    input wire logic [1:0] cfgType2,
    input wire logic [1:0] cfgRelation,
    input wire logic [15:0] cfgValue1,
    input wire logic [15:0] cfgValue2,
    // controls and results
    input wire logic restart,
    input wire logic startGroup,
    input wire logic stepAdvanceIn,
    input wire logic [12:0] groupSpeed,
    input wire logic busy,
    input wire logic stepChange
);
    logic [1:0] type1_q;
    logic [1:0] rel_q;
    logic [15:0] value1_q;
    logic [12:0] speed_q;
    // shadow of the settings as the block should have loaded them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            type1_q <= dgs_pkg::TYPE_RESET;
            rel_q <= dgs_pkg::REL_RESET;
            value1_q <= dgs_pkg::VALUE_RESET;
            speed_q <= dgs_pkg::SPEED_RESET;
        end else if (restart) begin
            type1_q <= cfgType1;
            rel_q <= cfgRelation;
            value1_q <= cfgValue1;
            speed_q <= (cfgSpeed > dgs_pkg::SPEED_MAX) ? dgs_pkg::SPEED_MAX : cfgSpeed;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence armNone;
        startGroup && !busy && type1_q == dgs_pkg::COND_NONE && rel_q == dgs_pkg::REL_NONE;
    endsequence
    sequence riseWhileArmed;
        type1_q == dgs_pkg::COND_EDGE && value1_q == dgs_pkg::EDGE_RISE
            && rel_q == dgs_pkg::REL_NONE && busy && $past(busy, 2) && $rose(stepAdvanceIn);
    endsequence
    AST_NONE_STEP: assert property (armNone |-> ##[2:4] stepChange)
        else $error("no step after unconditional group");
    AST_RISE_STEP: assert property (riseWhileArmed |-> ##[2:5] stepChange)
        else $error("rising edge gave no step");
    AST_STEP_ONE: assert property (stepChange |=> !stepChange)
        else $error("step pulse longer than one cycle");
    AST_STEP_IDLE: assert property (stepChange |-> !busy)
        else $error("busy still high with step");
    AST_NO_IDLE_STEP: assert property (!busy && !$past(busy) |-> !stepChange)
        else $error("step without armed group");
    AST_ARM: assert property (startGroup && !busy && !restart |-> ##[1:2] busy)
        else $error("group not armed");
    AST_ABORT: assert property (restart && busy |=> ##[0:1] !busy)
        else $error("restart did not abort");
    AST_SPEED_LOAD: assert property ($fell(restart) |-> ##[0:1] groupSpeed == speed_q)
        else $error("speed not loaded on restart");
endmodule : dgs_step_sequencer_monitor
bind dgs_step_sequencer dgs_step_sequencer_monitor u_mon (.core_clk, .nrst, .cfgSpeed,
    .cfgType1, .cfgType2, .cfgRelation, .cfgValue1, .cfgValue2, .restart, .startGroup,
    .stepAdvanceIn, .groupSpeed, .busy, .stepChange);

// [dgs_adv_switch.sv]
// model of the outside switch on the step-advance input
`timescale 1ns/10ps
module dgs_adv_switch #(
    parameter int HOLD = 4
) (
    // clock and wanted level
    input wire logic core_clk,
    input wire logic wantLevel,
    // switch output
    output logic stepAdvanceIn
);
    int holdCnt = 0;
    initial stepAdvanceIn = 1'b0;
    // each new level is held at least HOLD+1 cycles so the block cannot miss it
    always @(negedge core_clk) begin
        if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end else if (wantLevel !== stepAdvanceIn) begin
            stepAdvanceIn <= wantLevel;
            holdCnt <= HOLD;
        end
    end
endmodule : dgs_adv_switch

// [dgs_tb.sv]
// self-checking testbench of the data group step sequencer
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, restart = 1'b0, startGroup = 1'b0, wantLevel = 1'b0;
    logic [12:0] cfgSpeed = 13'h0000;
    logic [1:0] cfgType1 = 2'h0, cfgType2 = 2'h0, cfgRelation = 2'h0;
    logic [15:0] cfgValue1 = 16'h0000, cfgValue2 = 16'h0000;
    logic stepAdvanceIn, busy, stepChange;
    logic [12:0] groupSpeed;
    logic [12:0] expQ[$];
    logic [31:0] lfsr = 32'hD0902176;
    int mismatches = 0, compares = 0;
    // type1 type2 relation value1 value2 startLevel endLevel
    int cases[10][7] = '{'{0,0,0,7,9,0,0}, '{1,0,1,0,0,0,0}, '{2,0,0,0,0,0,1},
        '{2,0,0,1,0,1,0}, '{2,0,0,2,0,1,0}, '{3,0,0,0,0,0,1}, '{3,0,0,4,0,1,0},
        '{2,2,2,0,1,0,1}, '{0,2,0,0,0,0,0}, '{0,3,1,0,4,1,0}};
    always #4 core_clk = ~core_clk;
    dgs_step_sequencer u_dut (.core_clk, .nrst, .cfgSpeed, .cfgType1, .cfgType2,
        .cfgRelation, .cfgValue1, .cfgValue2, .restart, .startGroup, .stepAdvanceIn,
        .groupSpeed, .busy, .stepChange);
    dgs_adv_switch u_sw (.core_clk, .wantLevel, .stepAdvanceIn);
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // any step pulse must match the oldest note; none must come unannounced
    always @(negedge core_clk) begin
        if (stepChange === 1'b1) begin
            if (expQ.size() == 0) check("unexpected step", 13'h0000, 13'h0001);
            else check("groupSpeed", expQ.pop_front(), groupSpeed);
        end
    end
    task automatic run_case(input int c[7], input bit abort);
        logic [12:0] spd;
        logic [12:0] expSpd;
        lfsr = lfsr_next(lfsr);
        spd = lfsr[12:0];
        expSpd = (spd > dgs_pkg::SPEED_MAX) ? dgs_pkg::SPEED_MAX : spd;
        wantLevel = c[5][0];
        repeat (8) @(negedge core_clk);
        {cfgType1, cfgType2, cfgRelation} = {c[0][1:0], c[1][1:0], c[2][1:0]};
        {cfgValue1, cfgValue2, cfgSpeed} = {c[3][15:0], c[4][15:0], spd};
        restart = 1'b1;
        @(negedge core_clk);
        restart = 1'b0;
        cfgSpeed = ~spd;
        if (c[5] == c[6]) expQ.push_back(expSpd);
        repeat (2) @(negedge core_clk);
        startGroup = 1'b1;
        @(negedge core_clk);
        startGroup = 1'b0;
        if (abort) begin
            repeat (3) @(negedge core_clk);
            restart = 1'b1;
            @(negedge core_clk);
            restart = 1'b0;
            // the aborting restart also loaded the inverted speed on cfgSpeed
            expSpd = (~spd > dgs_pkg::SPEED_MAX) ? dgs_pkg::SPEED_MAX : ~spd;
        end
        if (c[5] != c[6]) begin
            repeat (5) @(negedge core_clk);
            startGroup = 1'b1;
            @(negedge core_clk);
            startGroup = 1'b0;
            wantLevel = c[6][0];
            expQ.push_back(expSpd);
        end
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        check("busy", 13'h0000, {12'h000, busy});
    endtask : run_case
    initial begin
        repeat (11) @(negedge core_clk);
        check("groupSpeed", dgs_pkg::SPEED_RESET, groupSpeed);
        @(negedge core_clk);
        nrst = 1'b1;
        repeat (3) @(negedge core_clk);
        foreach (cases[i]) run_case(cases[i], 1'b0);
        run_case(cases[5], 1'b1);
        check("pending", 13'h0000, 13'(expQ.size()));
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule : testbench
